// file: rtl/cit_pkg.sv
// Contract
// - External data move writes may target on-chip flash program memory.
// - Add, add-with-carry, subtract-with-borrow from bank register: 1 byte, 1 cycle.
// - Same arithmetic with direct or immediate source: 2 bytes, 2 cycles.
// - Arithmetic and logic with indirect RAM operand: 1 byte, 2 cycles.
// - Inc/dec acc or register 1 cycle, direct 2/2, indirect 2; pointer inc 1.
// - Multiply 4 cycles, divide 8 cycles, decimal adjust 1; all one byte.
// - AND, OR, XOR of immediate into direct byte: 3 bytes, 3 cycles.
// - Logic with register 1 cycle; with direct or immediate 2 bytes, 2 cycles.
// - Rotates, swap and clear of acc 1 cycle; complement of acc 2 cycles.
// - Direct-to-direct and immediate-to-direct moves: 3 bytes, 3 cycles.
// - Loading the 16-bit data pointer with a constant: 3 bytes, 3 cycles.
// - Code byte moves relative to pointer or counter: 1 byte, 3 cycles.
// - External data reads and writes by index or pointer: 1 byte, 3 cycles.
// - Push and pop of a direct byte: 2 bytes, 2 cycles.
// - Exchanges: indirect 1/2, register 1 cycle, direct 2 bytes 2 cycles.
// - Moves into indirect RAM take 2 cycles from acc, direct or immediate.
// - Register-acc moves 1 cycle; other direct or immediate moves 2/2.
// - Time counts in system clocks; most ops take one cycle per byte.
// - Opcode encodings and lengths follow the standard instruction set.
package cit_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Upper address byte used by the index-register form of the access
	localparam logic [7:0] XPAGE_RI = 8'h00;

	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_MUL = 4'h4;
	localparam logic [3:0] CYC_DIV = 4'h8;

	localparam logic [7:0] OP_MUL = 8'ha4;
	localparam logic [7:0] OP_DIV = 8'h84;
	localparam logic [7:0] OP_CPL_ACC = 8'hf4;
	localparam logic [7:0] OP_XRD_DP = 8'he0;
	localparam logic [7:0] OP_XWR_DP = 8'hf0;
	localparam logic [7:0] OP_XRD_RI = 8'he2;
	localparam logic [7:0] OP_XWR_RI = 8'hf2;
	localparam int unsigned OP_WR_BIT = 4;
	localparam int unsigned OP_RI_BIT = 1;

	typedef struct packed {
		logic [1:0] len;
		logic [3:0] cyc;
		logic known;
		logic xmove;
		logic xwrite;
		logic xri;
	} cit_decode_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic flash_wr;
		logic flash_erase;
	} cit_xreq_s;

	typedef enum logic {
		CIT_FETCH = 1'b0,
		CIT_EXEC = 1'b1
	} cit_phase_e;

	typedef struct packed {
		cit_phase_e phase;
		logic [15:0] pc;
		logic [7:0] opcode;
		logic [15:0] operands;
		cit_decode_s dec;
		logic [3:0] cyc_left;
		logic [1:0] bytes_left;
		logic retire;
		cit_xreq_s xreq;
	} cit_core_s;

	localparam cit_core_s CORE_RESET = '{phase: CIT_FETCH, pc: PC_RESET,
		default: '0};

endpackage : cit_pkg

// file: rtl/cit_len_decode.sv
`timescale 1ns/1ps
module cit_len_decode (
	input wire logic [7:0] opcode_in,
	output cit_pkg::cit_decode_s decode_out
);
	import cit_pkg::*;

	function automatic cit_decode_s decode_op(input logic [7:0] op);
		cit_decode_s d;
		d = '0;
		d.known = 1'b1;
		unique case (op) inside
		[8'h28:8'h2f], [8'h38:8'h3f], [8'h98:8'h9f]:
			{d.len, d.cyc} = {LEN_1, CYC_1};
		8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95:
			{d.len, d.cyc} = {LEN_2, CYC_2};
		8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h46, 8'h47,
		8'h56, 8'h57, 8'h66, 8'h67:
			{d.len, d.cyc} = {LEN_1, CYC_2};
		8'h04, 8'h14, [8'h08:8'h0f], [8'h18:8'h1f], 8'ha3:
			{d.len, d.cyc} = {LEN_1, CYC_1};
		8'h05, 8'h15:
			{d.len, d.cyc} = {LEN_2, CYC_2};
		8'h06, 8'h07, 8'h16, 8'h17:
			{d.len, d.cyc} = {LEN_1, CYC_2};
		OP_MUL:
			{d.len, d.cyc} = {LEN_1, CYC_MUL};
		OP_DIV:
			{d.len, d.cyc} = {LEN_1, CYC_DIV};
		8'h43, 8'h53, 8'h63, 8'h85, 8'h75, 8'h90:
			{d.len, d.cyc} = {LEN_3, CYC_3};
		[8'h48:8'h4f], [8'h58:8'h5f], [8'h68:8'h6f]:
			{d.len, d.cyc} = {LEN_1, CYC_1};
		8'h42, 8'h44, 8'h45, 8'h52, 8'h54, 8'h55, 8'h62, 8'h64,
		8'h65:
			{d.len, d.cyc} = {LEN_2, CYC_2};
		8'h03, 8'h13, 8'h23, 8'h33, 8'hc4, 8'he4, 8'hd4:
			{d.len, d.cyc} = {LEN_1, CYC_1};
		OP_CPL_ACC, 8'hc6, 8'hc7, 8'hd6, 8'hd7, 8'hf6, 8'hf7, 8'he6,
		8'he7:
			{d.len, d.cyc} = {LEN_1, CYC_2};
		8'h83, 8'h93:
			{d.len, d.cyc} = {LEN_1, CYC_3};
		OP_XRD_DP, OP_XWR_DP, OP_XRD_RI, 8'he3, OP_XWR_RI, 8'hf3: begin
			{d.len, d.cyc} = {LEN_1, CYC_3};
			d.xmove = 1'b1;
			d.xwrite = op[OP_WR_BIT];
			d.xri = op[OP_RI_BIT];
		end
		8'hc0, 8'hd0, 8'hc5, 8'ha6, 8'ha7, 8'h76, 8'h77:
			{d.len, d.cyc} = {LEN_2, CYC_2};
		[8'hc8:8'hcf], [8'he8:8'hef], [8'hf8:8'hff]:
			{d.len, d.cyc} = {LEN_1, CYC_1};
		8'he5, 8'h74, [8'ha8:8'haf], [8'h78:8'h7f], 8'hf5,
		[8'h88:8'h8f], 8'h86, 8'h87:
			{d.len, d.cyc} = {LEN_2, CYC_2};
		default: begin
			// Boolean and branch groups are outside this decoder
			{d.len, d.cyc} = {LEN_1, CYC_1};
			d.known = 1'b0;
		end
		endcase
		return d;
	endfunction : decode_op

	assign decode_out = decode_op(opcode_in);

endmodule : cit_len_decode

// file: rtl/cit_core.sv
`timescale 1ns/1ps
module cit_core (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] code_data_in,
	input wire logic code_ready_in,
	input wire logic [15:0] data_pointer16_in,
	input wire logic [7:0] index_reg_in,
	input wire logic [7:0] acc_in,
	input wire logic flash_write_en_in,
	input wire logic flash_erase_in,
	output logic [15:0] code_addr_out,
	output logic code_rd_out,
	output logic busy_out,
	output logic retire_out,
	output logic [7:0] retire_opcode_out,
	output logic [15:0] retire_operands_out,
	output logic [1:0] retire_len_out,
	output logic [3:0] retire_cycles_out,
	output logic retire_known_out,
	output cit_pkg::cit_xreq_s xreq_out
);
	import cit_pkg::*;

	cit_core_s st_reg;
	cit_core_s st_next;
	cit_decode_s dec_now;
	logic needs_byte;
	logic stall;

	// Program memory answers combinationally for the address on the port
	cit_len_decode u_decode (
		.opcode_in(code_data_in),
		.decode_out(dec_now)
	);

	assign needs_byte = (st_reg.phase == CIT_FETCH) ||
		(st_reg.bytes_left != 2'h0);
	// A wait from program memory freezes the whole sequence
	assign stall = needs_byte && !code_ready_in;

	always_comb begin
		st_next = st_reg;
		st_next.retire = 1'b0;
		st_next.xreq.rd = 1'b0;
		st_next.xreq.wr = 1'b0;
		st_next.xreq.flash_wr = 1'b0;
		st_next.xreq.flash_erase = 1'b0;
		unique case (st_reg.phase)
		CIT_FETCH: begin
			if (code_ready_in) begin
				st_next.opcode = code_data_in;
				st_next.dec = dec_now;
				st_next.operands = 16'h0000;
				st_next.pc = st_reg.pc + 16'h0001;
				st_next.bytes_left = dec_now.len - LEN_1;
				st_next.cyc_left = dec_now.cyc - CYC_1;
				if (dec_now.cyc == CYC_1) begin
					// Single-cycle ops let the next opcode in at once
					st_next.retire = 1'b1;
				end else begin
					st_next.phase = CIT_EXEC;
				end
			end
		end
		CIT_EXEC: begin
			if (!stall) begin
				if (st_reg.bytes_left != 2'h0) begin
					// Last operand byte lands in the low half
					st_next.operands = {st_reg.operands[7:0],
						code_data_in};
					st_next.pc = st_reg.pc + 16'h0001;
					st_next.bytes_left = st_reg.bytes_left - 2'h1;
				end
				st_next.cyc_left = st_reg.cyc_left - CYC_1;
				if (st_reg.cyc_left == CYC_1) begin
					st_next.phase = CIT_FETCH;
					st_next.retire = 1'b1;
					if (st_reg.dec.xmove) begin
						st_next.xreq.addr = st_reg.dec.xri ?
							{XPAGE_RI, index_reg_in} : data_pointer16_in;
						st_next.xreq.wdata = acc_in;
						if (!st_reg.dec.xwrite) begin
							st_next.xreq.rd = 1'b1;
						end else if (flash_write_en_in) begin
							// Flash writes never reach external data space
							st_next.xreq.flash_wr = !flash_erase_in;
							st_next.xreq.flash_erase = flash_erase_in;
						end else begin
							st_next.xreq.wr = 1'b1;
						end
					end
				end
			end
		end
		endcase
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= CORE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign code_addr_out = st_reg.pc;
	assign code_rd_out = needs_byte;
	assign busy_out = (st_reg.phase == CIT_EXEC);
	assign retire_out = st_reg.retire;
	assign retire_opcode_out = st_reg.opcode;
	assign retire_operands_out = st_reg.operands;
	assign retire_len_out = st_reg.dec.len;
	assign retire_cycles_out = st_reg.dec.cyc;
	assign retire_known_out = st_reg.dec.known;
	assign xreq_out = st_reg.xreq;

	// Checking aids: unstalled cycles per instruction and its start pc
	logic [3:0] gap_reg;
	logic [15:0] start_pc_reg;
	logic fetch_take;

	assign fetch_take = (st_reg.phase == CIT_FETCH) && code_ready_in;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			gap_reg <= 4'h0;
			start_pc_reg <= PC_RESET;
		end else begin
			if (retire_out) begin
				gap_reg <= stall ? 4'h0 : 4'h1;
			end else if (!stall && gap_reg != 4'hf) begin
				gap_reg <= gap_reg + 4'h1;
			end
			if (fetch_take) begin
				start_pc_reg <= st_reg.pc;
			end
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);

	a_bank_arith_time:
	assert property (retire_out && (retire_opcode_out inside
		{[8'h28:8'h2f], [8'h38:8'h3f], [8'h98:8'h9f]})
		|-> gap_reg == CYC_1 && retire_len_out == LEN_1)
		else $error("bank register arithmetic timing wrong");

	a_direct_arith_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'h24, 8'h25, 8'h34, 8'h35, 8'h94, 8'h95})
		|-> gap_reg == CYC_2 && retire_len_out == LEN_2)
		else $error("direct or immediate arithmetic timing wrong");

	a_indirect_alu_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h56, 8'h57})
		|-> gap_reg == CYC_2 && retire_len_out == LEN_1)
		else $error("indirect operand timing wrong");

	a_incdec_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'h05, 8'h15}) |-> gap_reg == CYC_2 && retire_len_out == LEN_2)
		else $error("direct increment or decrement timing wrong");

	a_pointer_inc_time:
	assert property (retire_out && retire_opcode_out == 8'ha3
		|-> gap_reg == CYC_1)
		else $error("pointer increment timing wrong");

	a_multiply_span:
	assert property (fetch_take && code_data_in == OP_MUL
		|=> busy_out [*3] ##1 (retire_out && !busy_out))
		else $error("multiply span is not four cycles");

	a_divide_span:
	assert property (fetch_take && code_data_in == OP_DIV
		|=> busy_out [*7] ##1 (retire_out && !busy_out))
		else $error("divide span is not eight cycles");

	a_logic_imm_direct:
	assert property (retire_out && (retire_opcode_out inside
		{8'h43, 8'h53, 8'h63}) |-> gap_reg == CYC_3 &&
		retire_len_out == LEN_3)
		else $error("logic immediate to direct timing wrong");

	a_logic_acc_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'h42, 8'h52, 8'h62, 8'h44, 8'h54, 8'h64})
		|-> gap_reg == CYC_2 && retire_len_out == LEN_2)
		else $error("logic with direct or immediate timing wrong");

	a_complement_span:
	assert property (fetch_take && code_data_in == OP_CPL_ACC
		|=> busy_out ##1 (retire_out && retire_cycles_out == CYC_2))
		else $error("accumulator complement span wrong");

	a_three_byte_move:
	assert property (retire_out && (retire_opcode_out inside
		{8'h85, 8'h75}) |-> gap_reg == CYC_3 &&
		code_addr_out - start_pc_reg == 16'h0003)
		else $error("three byte move timing wrong");

	a_pointer_load:
	assert property (retire_out && retire_opcode_out == 8'h90
		|-> gap_reg == CYC_3 && retire_len_out == LEN_3)
		else $error("pointer load timing wrong");

	a_code_move_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'h83, 8'h93}) |-> gap_reg == CYC_3 && retire_len_out == LEN_1)
		else $error("code byte move timing wrong");

	a_external_data_space_access:
	assert property ((xreq_out.rd || xreq_out.wr || xreq_out.flash_wr ||
		xreq_out.flash_erase) |-> retire_out && gap_reg == CYC_3 &&
		retire_len_out == LEN_1)
		else $error("external access not at end of three cycles");

	a_flash_route:
	assert property ((xreq_out.flash_wr || xreq_out.flash_erase)
		|-> $past(flash_write_en_in) && !xreq_out.wr &&
		retire_opcode_out[OP_WR_BIT])
		else $error("flash write routed wrongly");

	a_flash_block:
	assert property (busy_out && st_reg.dec.xwrite &&
		st_reg.cyc_left == CYC_1 && flash_write_en_in
		|=> !xreq_out.wr && (xreq_out.flash_wr || xreq_out.flash_erase))
		else $error("flash enabled write leaked to external space");

	a_stack_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'hc0, 8'hd0}) |-> gap_reg == CYC_2 && retire_len_out == LEN_2)
		else $error("push or pop timing wrong");

	a_exchange_time:
	assert property (retire_out && (retire_opcode_out inside
		{8'hc6, 8'hc7, 8'hd6, 8'hd7}) |-> gap_reg == CYC_2 &&
		retire_len_out == LEN_1)
		else $error("indirect exchange timing wrong");

	a_indirect_store:
	assert property (retire_out && (retire_opcode_out inside
		{8'hf6, 8'hf7, 8'ha6, 8'ha7, 8'h76, 8'h77})
		|-> gap_reg == CYC_2)
		else $error("indirect store timing wrong");

	a_reg_move_time:
	assert property (retire_out && (retire_opcode_out inside
		{[8'he8:8'hef], [8'hf8:8'hff]}) |-> gap_reg == CYC_1)
		else $error("register move timing wrong");

	a_len_within_cycles:
	assert property (retire_out |-> {2'b00, retire_len_out} <=
		retire_cycles_out)
		else $error("instruction longer than its cycle count");

	a_pc_advance:
	assert property (retire_out |-> code_addr_out - start_pc_reg ==
		{14'h0000, retire_len_out})
		else $error("program counter did not advance by length");

	a_next_start:
	assert property (retire_out |-> gap_reg == retire_cycles_out &&
		!busy_out)
		else $error("next instruction did not follow the count");

	a_xstrobe_single:
	assert property ($onehot0({xreq_out.rd, xreq_out.wr, xreq_out.flash_wr,
		xreq_out.flash_erase}))
		else $error("more than one external strobe at once");

	a_xaddr_source:
	assert property ((xreq_out.rd || xreq_out.wr || xreq_out.flash_wr ||
		xreq_out.flash_erase) |-> xreq_out.addr ==
		(retire_opcode_out[OP_RI_BIT] ? {XPAGE_RI, $past(index_reg_in)} :
		$past(data_pointer16_in)))
		else $error("external access address from wrong source");

	a_xwrite_data:
	assert property ((xreq_out.wr || xreq_out.flash_wr ||
		xreq_out.flash_erase) |-> xreq_out.wdata == $past(acc_in))
		else $error("external write data is not the accumulator");

	a_stall_freeze:
	assert property (busy_out && stall |=> busy_out &&
		$stable(code_addr_out) && !retire_out)
		else $error("program memory wait did not freeze the sequence");

	a_short_operands:
	assert property (retire_out && retire_len_out == LEN_1
		|-> retire_operands_out == 16'h0000)
		else $error("one byte instruction shows operand bytes");

	c_single_cycle_run: cover property (retire_out && retire_cycles_out ==
		CYC_1 ##1 retire_out && retire_cycles_out == CYC_1);
	c_divide_done: cover property (retire_out && retire_opcode_out ==
		OP_DIV);
	c_flash_write: cover property (xreq_out.flash_wr);
	c_flash_erase: cover property (xreq_out.flash_erase);
	c_code_wait: cover property (busy_out && stall);

endmodule : cit_core

// file: sim/cit_code_mem.sv
`timescale 1ns/1ps
module cit_code_mem (
	input wire logic clock_in,
	input wire logic [15:0] addr_in,
	input wire logic rd_in,
	input wire logic stall_in,
	output logic [7:0] data_out,
	output logic ready_out
);
	logic [7:0] mem [0:255];
	logic [7:0] last_reg = 8'h00;
	assign ready_out = rd_in & ~stall_in;
	// Outside a take the byte changes every cycle so a stale read shows up
	assign data_out = ready_out ? mem[addr_in[7:0]] : ~last_reg;
	always @(posedge clock_in) begin
		last_reg <= data_out;
	end
endmodule : cit_code_mem

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cit_pkg::*;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [15:0] data_pointer16_in = 16'h0000;
	logic [7:0] index_reg_in = 8'h00;
	logic [7:0] acc_in = 8'h00;
	logic flash_write_en_in = 1'b0;
	logic flash_erase_in = 1'b0;
	logic stall_in = 1'b0;
	logic [7:0] code_data_in;
	logic code_ready_in;
	logic [15:0] code_addr_out;
	logic code_rd_out;
	logic busy_out;
	logic retire_out;
	logic [7:0] retire_opcode_out;
	logic [15:0] retire_operands_out;
	logic [1:0] retire_len_out;
	logic [3:0] retire_cycles_out;
	logic retire_known_out;
	cit_xreq_s xreq_out;
	int bad_count = 0;
	int total_checks = 0;
	// Entry: opcode, byte length, cycle count
	logic [15:0] prog [0:44] = '{
		16'h2811, 16'h3422, 16'h9522, 16'h2612, 16'h0411, 16'h0522,
		16'h1712, 16'ha311, 16'ha414, 16'h8418, 16'hd411, 16'h5333,
		16'h4333, 16'h6333, 16'h4a11, 16'h6222, 16'h2311, 16'h1311,
		16'hc411, 16'he411, 16'hf412, 16'h8533, 16'h7533, 16'h9033,
		16'h9313, 16'h8313, 16'he013, 16'he213, 16'hf013, 16'hf213,
		16'hc022, 16'hd022, 16'hd612, 16'hcb11, 16'hc522, 16'hf612,
		16'ha722, 16'h7622, 16'hed11, 16'hff11, 16'h7422, 16'h6712,
		16'h5422, 16'h1411, 16'haf22};

	always #10 clock_in = ~clock_in;

	cit_code_mem cit_code_mem_i (.clock_in(clock_in),
		.addr_in(code_addr_out), .rd_in(code_rd_out), .stall_in(stall_in),
		.data_out(code_data_in), .ready_out(code_ready_in));

	cit_core cit_core_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.code_data_in(code_data_in), .code_ready_in(code_ready_in),
		.data_pointer16_in(data_pointer16_in), .index_reg_in(index_reg_in),
		.acc_in(acc_in), .flash_write_en_in(flash_write_en_in),
		.flash_erase_in(flash_erase_in), .code_addr_out(code_addr_out),
		.code_rd_out(code_rd_out), .busy_out(busy_out),
		.retire_out(retire_out), .retire_opcode_out(retire_opcode_out),
		.retire_operands_out(retire_operands_out),
		.retire_len_out(retire_len_out),
		.retire_cycles_out(retire_cycles_out),
		.retire_known_out(retire_known_out), .xreq_out(xreq_out));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic load_prog;
		int a;
		a = 0;
		for (int i = 0; i < 256; i++) cit_code_mem_i.mem[i] = 8'h00;
		for (int k = 0; k < 45; k++) begin
			cit_code_mem_i.mem[a] = prog[k][15:8];
			for (int j = 1; j < 32'(prog[k][7:4]); j++) begin
				cit_code_mem_i.mem[a + j] = 8'(a + j) ^ 8'h5a;
			end
			a += 32'(prog[k][7:4]);
		end
	endtask : load_prog

	task automatic do_reset;
		sys_rst_in = 1'b1;
		repeat (3) @(posedge clock_in);
		#1 sys_rst_in = 1'b0;
	endtask : do_reset

	// Walks the program from address 0, timing each instruction
	task automatic run_prog(input bit waits, input int limit);
		int pc, count, k, n;
		bit stalled, xm, wr;
		logic [15:0] e, opnd, xa;
		logic [3:0] xs;
		pc = 0;
		count = 0;
		k = 0;
		n = 0;
		stalled = 0;
		while (k < limit && n < 3000) begin
			@(posedge clock_in);
			#1;
			n++;
			if (!stalled) count++;
			// Wait states only on operand bytes, never on an opcode fetch
			stalled = waits && code_rd_out && !retire_out && (n % 3 == 0);
			stall_in = stalled;
			check(32'(busy_out), 32'(!retire_out));
			if (retire_out) begin
				e = prog[k];
				opnd = 16'h0000;
				if (e[7:4] == 4'h2) opnd = {8'h00, 8'(pc + 1) ^ 8'h5a};
				if (e[7:4] == 4'h3) opnd = {8'(pc + 1) ^ 8'h5a, 8'(pc + 2) ^ 8'h5a};
				xm = e[15:8] inside {OP_XRD_DP, OP_XRD_RI, OP_XWR_DP, OP_XWR_RI};
				wr = e[8 + OP_WR_BIT];
				xa = e[8 + OP_RI_BIT] ? {XPAGE_RI, index_reg_in} : data_pointer16_in;
				xs = {xm & ~wr, xm & wr & ~flash_write_en_in,
					xm & wr & flash_write_en_in & ~flash_erase_in,
					xm & wr & flash_write_en_in & flash_erase_in};
				check(32'(retire_opcode_out), 32'(e[15:8]));
				check(32'(retire_len_out), 32'(e[7:4]));
				check(32'(retire_cycles_out), 32'(e[3:0]));
				check(32'(count), 32'(e[3:0]));
				check(32'(retire_known_out), 32'h1);
				check(32'(retire_operands_out), 32'(opnd));
				check(32'(code_addr_out), 32'(pc + e[7:4]));
				check(32'({xreq_out.rd, xreq_out.wr, xreq_out.flash_wr,
					xreq_out.flash_erase}), 32'(xs));
				if (xm) check(32'(xreq_out.addr), 32'(xa));
				if (xm && wr) check(32'(xreq_out.wdata), 32'(acc_in));
				pc += 32'(e[7:4]);
				k++;
				count = 0;
			end
		end
		stall_in = 1'b0;
		check(32'(k), 32'(limit));
	endtask : run_prog

	task automatic test_timing;
		data_pointer16_in = 16'h1234;
		index_reg_in = 8'h5c;
		acc_in = 8'ha7;
		do_reset();
		run_prog(1'b0, 45);
		// Blank memory past the program decodes as an unknown one-cycle op
		@(posedge clock_in);
		#1;
		check(32'({retire_out, retire_known_out, retire_opcode_out}),
			32'h200);
		$display("test_timing done");
	endtask : test_timing

	task automatic test_flash_write_waits;
		data_pointer16_in = 16'hfe01;
		index_reg_in = 8'h81;
		acc_in = 8'h3c;
		flash_write_en_in = 1'b1;
		flash_erase_in = 1'b0;
		do_reset();
		run_prog(1'b1, 45);
		$display("test_flash_write_waits done");
	endtask : test_flash_write_waits

	task automatic test_erase_and_reset;
		flash_erase_in = 1'b1;
		data_pointer16_in = 16'h8000;
		index_reg_in = 8'hff;
		acc_in = 8'h00;
		do_reset();
		run_prog(1'b0, 20);
		// Reset lands in the middle of the instruction stream
		sys_rst_in = 1'b1;
		#1;
		check(32'({code_addr_out, code_rd_out, busy_out, retire_out}),
			32'({16'h0000, 3'b100}));
		check(32'(xreq_out), 32'h0);
		do_reset();
		run_prog(1'b0, 45);
		$display("test_erase_and_reset done");
	endtask : test_erase_and_reset

	initial begin
		load_prog();
		test_timing();
		test_flash_write_waits();
		test_erase_and_reset();
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge clock_in);
		bad_count++;
		tally_and_finish();
	end
endmodule : testbench
